// ==== nsb_pkg.sv ====
// Package for the negate and subtract-with-borrow execution block.
// Assumes a 16-bit instruction word and an 8-bit data path.
package nsb_pkg;

    // ------------------------------------------------------------------
    // Instruction encoding
    // ------------------------------------------------------------------
    localparam logic [6:0] NEG_OPCODE      = 7'h36;
    localparam logic [5:0] SUB_OPCODE      = 6'h16;
    localparam int         NEG_OPC_LSB     = 9;
    localparam int         SUB_OPC_LSB     = 10;
    localparam int         DEST_BIT        = 9;
    localparam int         BANK_BIT        = 8;
    localparam int         ADDR_MSB        = 7;

    // ------------------------------------------------------------------
    // Access bank split and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  ACCESS_SPLIT   = 8'h80;
    localparam logic [3:0]  ACCESS_HI_BANK = 4'hf;
    localparam logic [3:0]  ACCESS_LO_BANK = 4'h0;
    localparam logic [7:0]  DATA_RST       = 8'h00;
    localparam logic [11:0] ADDR_RST       = 12'h000;

    // ------------------------------------------------------------------
    // Status flag positions
    // ------------------------------------------------------------------
    localparam int FLAG_C  = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z  = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N  = 4;
    localparam logic [4:0] FLAGS_RST = 5'h00;

    typedef enum {
        ST_FETCH,
        ST_READ,
        ST_WRITE
    } nsb_state_t;

endpackage

// ==== nsb_exec.sv ====
// Execution stage for the negate and subtract-with-borrow instructions.
// Assumes a data memory with one-cycle registered read data, and that the
// issuer holds I_INSTR_VALID until O_DONE pulses.
//
// Function
// - Negate replaces the addressed byte with its inverse plus one, in place.
// - Negate decodes as 0110 110 then bank bit then eight address bits.
// - Both instructions update negative, overflow, carry, digit carry, zero.
// - Bank bit 0 resolves the address in the access bank, ignoring bank reg.
// - Bank bit 1 forms the address from the bank select register.
// - Subtract-with-borrow gives file minus working minus inverted carry.
// - Subtract-with-borrow decodes as 0101 10, dest bit, bank bit, address.
`timescale 1ns/1ns

module nsb_exec
    import nsb_pkg::*;
(
    // Clock and reset
    input  wire logic        I_MCLK,
    input  wire logic        I_RESETN,
    // Instruction issue
    input  wire logic        I_INSTR_VALID,
    input  wire logic [15:0] I_INSTR,
    // Core state
    input  wire logic [3:0]  I_BANK_SELECT_REGISTER,
    input  wire logic [7:0]  I_WORKING_REGISTER,
    input  wire logic        I_CARRY,
    // Data memory
    input  wire logic [7:0]  I_MEM_RDATA,
    output logic      [11:0] O_MEM_ADDR,
    output logic             O_MEM_RD,
    output logic             O_MEM_WR,
    output logic      [7:0]  O_MEM_WDATA,
    // Results
    output logic             O_WORKING_REGISTER_WR,
    output logic      [7:0]  O_WORKING_REGISTER_WDATA,
    output logic             O_FLAGS_WR,
    output logic      [4:0]  O_FLAGS,
    output logic             O_DONE,
    output logic             O_ILLEGAL
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic is_neg(input logic [15:0] w);
        return w[15:NEG_OPC_LSB] == NEG_OPCODE;
    endfunction

    function automatic logic is_sub(input logic [15:0] w);
        return w[15:SUB_OPC_LSB] == SUB_OPCODE;
    endfunction

    // Access bank covers low half of bank 0 and high half of the top bank.
    function automatic logic [11:0] resolve(input logic [15:0] w,
                                            input logic [3:0]  bank_select_register);
        logic [7:0] f;
        f = w[ADDR_MSB:0];
        if (w[BANK_BIT]) begin
            return {bank_select_register, f};
        end
        return {(f >= ACCESS_SPLIT) ? ACCESS_HI_BANK : ACCESS_LO_BANK,
                f};
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    nsb_state_t  state_ff, nxt_state;
    logic        neg_ff, nxt_neg;
    logic        dest_ff, nxt_dest;
    logic [11:0] addr_ff, nxt_addr;
    logic        rd_ff, nxt_rd;
    logic        wr_ff, nxt_wr;
    logic [7:0]  wdata_ff, nxt_wdata;
    logic        working_register_wr_ff, nxt_working_register_wr;
    logic [7:0]  working_register_data_ff, nxt_working_register_data;
    logic        flags_wr_ff, nxt_flags_wr;
    logic [4:0]  flags_ff, nxt_flags;
    logic        done_ff, nxt_done;
    logic        ill_ff, nxt_ill;

    // Arithmetic. Both operations are a + ~b + cin on the 8-bit path.
    // Negate is formed as zero minus the byte, so it shares the subtract
    // path with no extra adder; the price is that its carry reads as
    // "no borrow", set only when the byte was zero.
    // Carry out of bit 7 means no borrow for both operations, and the
    // nibble carry means no borrow out of the low four bits.
    // Overflow follows the signed subtract rule: the operands differ in
    // sign and the result takes the sign of the subtrahend.
    // The working register and carry are read live in the write cycle, so
    // the core must not change them while an operation is in flight.
    // A reset in mid-operation drops the operation with no write at all.
    logic [7:0] op_a;
    logic [7:0] op_b;
    logic       cin;
    logic [8:0] sum;
    logic [4:0] low;
    logic [7:0] res;
    logic       ovf;

    always_comb begin
        if (neg_ff) begin
            op_a = 8'h00;
            op_b = I_MEM_RDATA;
            cin  = 1'b1;
        end else begin
            op_a = I_MEM_RDATA;
            op_b = I_WORKING_REGISTER;
            cin  = I_CARRY;
        end
        sum = {1'b0, op_a} + {1'b0, ~op_b} + {8'h00, cin};
        low = {1'b0, op_a[3:0]} + {1'b0, ~op_b[3:0]} + {4'h0, cin};
        res = sum[7:0];
        ovf = (op_a[7] != op_b[7]) && (res[7] != op_a[7]);
    end

    // ------------------------------------------------------------------
    // Sequencer: fetch, read operand, write destination
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state     = state_ff;
        nxt_neg       = neg_ff;
        nxt_dest      = dest_ff;
        nxt_addr      = addr_ff;
        nxt_rd        = 1'b0;
        nxt_wr        = 1'b0;
        nxt_wdata     = wdata_ff;
        nxt_working_register_wr   = 1'b0;
        nxt_working_register_data = working_register_data_ff;
        nxt_flags_wr  = 1'b0;
        nxt_flags     = flags_ff;
        nxt_done      = 1'b0;
        nxt_ill       = 1'b0;
        case (state_ff)
            ST_FETCH: begin
                if (I_INSTR_VALID && !done_ff) begin
                    if (is_neg(I_INSTR) || is_sub(I_INSTR)) begin
                        nxt_neg   = is_neg(I_INSTR);
                        // Negate always writes back in place.
                        nxt_dest  = is_neg(I_INSTR) | I_INSTR[DEST_BIT];
                        nxt_addr  = resolve(I_INSTR,
                                            I_BANK_SELECT_REGISTER);
                        nxt_rd    = 1'b1;
                        nxt_state = ST_READ;
                    end else begin
                        nxt_ill  = 1'b1;
                        nxt_done = 1'b1;
                    end
                end
            end
            ST_READ: begin
                // Read data appears on the cycle after the strobe.
                nxt_state = ST_WRITE;
            end
            ST_WRITE: begin
                nxt_flags[FLAG_C]  = sum[8];
                nxt_flags[FLAG_DC] = low[4];
                nxt_flags[FLAG_Z]  = (res == DATA_RST);
                nxt_flags[FLAG_OV] = ovf;
                nxt_flags[FLAG_N]  = res[7];
                nxt_flags_wr       = 1'b1;
                if (dest_ff) begin
                    nxt_wr    = 1'b1;
                    nxt_wdata = res;
                end else begin
                    nxt_working_register_wr   = 1'b1;
                    nxt_working_register_data = res;
                end
                nxt_done  = 1'b1;
                nxt_state = ST_FETCH;
            end
            default: begin
                nxt_state = ST_FETCH;
            end
        endcase
    end

    always_ff @(posedge I_MCLK) begin
        if (!I_RESETN) begin
            state_ff     <= ST_FETCH;
            neg_ff       <= 1'b0;
            dest_ff      <= 1'b0;
            addr_ff      <= ADDR_RST;
            rd_ff        <= 1'b0;
            wr_ff        <= 1'b0;
            wdata_ff     <= DATA_RST;
            working_register_wr_ff   <= 1'b0;
            working_register_data_ff <= DATA_RST;
            flags_wr_ff  <= 1'b0;
            flags_ff     <= FLAGS_RST;
            done_ff      <= 1'b0;
            ill_ff       <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            neg_ff       <= nxt_neg;
            dest_ff      <= nxt_dest;
            addr_ff      <= nxt_addr;
            rd_ff        <= nxt_rd;
            wr_ff        <= nxt_wr;
            wdata_ff     <= nxt_wdata;
            working_register_wr_ff   <= nxt_working_register_wr;
            working_register_data_ff <= nxt_working_register_data;
            flags_wr_ff  <= nxt_flags_wr;
            flags_ff     <= nxt_flags;
            done_ff      <= nxt_done;
            ill_ff       <= nxt_ill;
        end
    end

    assign O_MEM_ADDR   = addr_ff;
    assign O_MEM_RD     = rd_ff;
    assign O_MEM_WR     = wr_ff;
    assign O_MEM_WDATA  = wdata_ff;
    assign O_WORKING_REGISTER_WR    = working_register_wr_ff;
    assign O_WORKING_REGISTER_WDATA = working_register_data_ff;
    assign O_FLAGS_WR   = flags_wr_ff;
    assign O_FLAGS      = flags_ff;
    assign O_DONE       = done_ff;
    assign O_ILLEGAL    = ill_ff;

endmodule

// ==== nsb_exec_assertions.sv ====
// Checker for the negate and subtract-with-borrow block.
// Assumes the issuer holds instruction and core state until done.
`timescale 1ns/1ns
module nsb_exec_assertions
    import nsb_pkg::*;
(
    input wire logic        I_MCLK, I_RESETN, I_INSTR_VALID, I_CARRY,
    input wire logic [15:0] I_INSTR,
    input wire logic [3:0]  I_BANK_SELECT_REGISTER,
    input wire logic [7:0]  I_WORKING_REGISTER, I_MEM_RDATA,
    input wire logic [11:0] O_MEM_ADDR,
    input wire logic        O_MEM_RD, O_MEM_WR, O_WORKING_REGISTER_WR,
    input wire logic [7:0]  O_MEM_WDATA, O_WORKING_REGISTER_WDATA,
    input wire logic        O_FLAGS_WR, O_DONE, O_ILLEGAL,
    input wire logic [4:0]  O_FLAGS
);
    logic       neg, sub;
    logic [7:0] res;
    assign neg = I_INSTR[15:9] == NEG_OPCODE;
    assign sub = I_INSTR[15:10] == SUB_OPCODE;
    assign res = O_MEM_WR ? O_MEM_WDATA : O_WORKING_REGISTER_WDATA;
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (!I_RESETN);
    sequence s_take_legal;
        $rose(I_INSTR_VALID) && (neg || sub);
    endsequence
    sequence s_walk;
        O_MEM_RD ##1 !O_DONE ##1 O_DONE && O_FLAGS_WR && !O_ILLEGAL;
    endsequence
    a_legal_walk: assert property (s_take_legal |=> s_walk)
        else $error("legal op walk broken");
    a_illegal_quick: assert property ($rose(I_INSTR_VALID) && !neg && !sub
        |=> O_DONE && O_ILLEGAL && !O_MEM_WR) else $error("bad decode");
    a_neg_value: assert property (O_DONE && neg |-> O_MEM_WR && !O_WORKING_REGISTER_WR
        && O_MEM_WDATA == 8'h00 - $past(I_MEM_RDATA)) else $error("neg");
    a_sub_value: assert property (O_DONE && sub |-> res == $past(I_MEM_RDATA)
        - I_WORKING_REGISTER - {7'h00, !I_CARRY}) else $error("sub value");
    a_sub_dest: assert property (O_DONE && sub |-> O_WORKING_REGISTER_WR
        == !I_INSTR[DEST_BIT] && O_MEM_WR == I_INSTR[DEST_BIT])
        else $error("sub destination");
    a_bank_access: assert property (O_MEM_RD && !I_INSTR[BANK_BIT] |->
        O_MEM_ADDR == {I_INSTR[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK,
        I_INSTR[7:0]}) else $error("access bank address");
    a_bank_reg: assert property (O_MEM_RD && I_INSTR[BANK_BIT] |->
        O_MEM_ADDR == {I_BANK_SELECT_REGISTER, I_INSTR[7:0]})
        else $error("bank register address");
    a_zero_neg: assert property (O_FLAGS_WR |-> O_FLAGS[FLAG_Z]
        == (res == 8'h00) && O_FLAGS[FLAG_N] == res[7]) else $error("flags");
    a_same_place: assert property (O_MEM_WR |->
        O_MEM_ADDR == $past(O_MEM_ADDR, 2)) else $error("write address");
endmodule
bind nsb_exec nsb_exec_assertions u_chk (.*);

// ==== tb_nsb_exec.sv ====
// Testbench for the negate and subtract-with-borrow block.
// Assumes memory answers with one byte held for the whole operation.
`timescale 1ns/1ns
module tb_nsb_exec;
    import nsb_pkg::*;
    logic        I_MCLK, I_RESETN, I_INSTR_VALID, I_CARRY;
    logic [15:0] I_INSTR;
    logic [3:0]  I_BANK_SELECT_REGISTER;
    logic [7:0]  I_WORKING_REGISTER, I_MEM_RDATA, O_MEM_WDATA, O_WORKING_REGISTER_WDATA;
    logic [11:0] O_MEM_ADDR;
    logic        O_MEM_RD, O_MEM_WR, O_WORKING_REGISTER_WR, O_FLAGS_WR, O_DONE, O_ILLEGAL;
    logic [4:0]  O_FLAGS;
    int          mismatches = 0;
    int          cmp_count = 0;
    logic        rd_seen;
    int          waited;
    nsb_exec DUT (.*);
    initial begin
        I_MCLK = 1'b0;
        forever #50 I_MCLK = ~I_MCLK;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("Error t=%0t got %h exp %h", $time, got, exp);
            mismatches++;
        end
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Waits a bounded time for done; a hang ends the run.
    task automatic issue(input logic [15:0] ins);
        I_INSTR = ins;
        I_INSTR_VALID = 1'b1;
        rd_seen = 1'b0;
        waited = 0;
        for (int n = 0; n < 8 && O_DONE !== 1'b1; n++) begin
            @(posedge I_MCLK);
            #1;
            rd_seen = rd_seen | O_MEM_RD;
            waited++;
        end
        if (O_DONE !== 1'b1) begin
            mismatches++;
            tally_and_finish();
        end
    endtask
    task automatic op(input logic [15:0] ins, input logic [7:0] f, w,
                      input logic c, input logic [3:0] b);
        logic       neg, dm;
        logic [8:0] full;
        logic [4:0] lo;
        logic [7:0] r;
        neg = ins[15:9] == NEG_OPCODE;
        dm = neg || ins[DEST_BIT];
        full = neg ? 9'h000 - {1'b0, f} : {1'b0, f} - w - {8'h00, !c};
        lo = neg ? 5'h00 - {1'b0, f[3:0]} : {1'b0, f[3:0]} - w[3:0] - !c;
        r = full[7:0];
        {I_MEM_RDATA, I_WORKING_REGISTER, I_CARRY} = {f, w, c};
        I_BANK_SELECT_REGISTER = b;
        issue(ins);
        chk({rd_seen, waited[3:0]}, {1'b1, 4'h3});
        chk({O_MEM_WR, O_WORKING_REGISTER_WR, O_FLAGS_WR, O_ILLEGAL}, {dm, !dm, 2'b10});
        chk(dm ? O_MEM_WDATA : O_WORKING_REGISTER_WDATA, r);
        chk(O_FLAGS, {r[7], neg ? f == 8'h80 : f[7] != w[7] && r[7] != f[7],
            r == 8'h00, !lo[4], !full[8]});
        chk(O_MEM_ADDR, ins[BANK_BIT] ? {b, ins[7:0]} :
            {ins[7] ? ACCESS_HI_BANK : ACCESS_LO_BANK, ins[7:0]});
        I_INSTR_VALID = 1'b0;
        @(posedge I_MCLK);
        #1;
    endtask
    task automatic t_negate();
        op({NEG_OPCODE, 1'b0, 8'h3a}, 8'h3a, 8'h55, 1'b0, 4'h7);
        op({NEG_OPCODE, 1'b0, 8'hf0}, 8'h00, 8'h55, 1'b1, 4'h7);
        op({NEG_OPCODE, 1'b1, 8'h81}, 8'h80, 8'h00, 1'b0, 4'h5);
    endtask
    task automatic t_sub();
        for (int i = 0; i < 4; i++) begin
            op({SUB_OPCODE, i[1], 1'b0, 8'h90}, 8'h19, 8'h0d, i[0], 4'h3);
        end
        op({SUB_OPCODE, 2'b11, 8'h12}, 8'h80, 8'h01, 1'b1, 4'h9);
    endtask
    // An unknown opcode must end quickly without touching any state.
    task automatic t_illegal();
        issue(16'h6e00);
        chk({rd_seen, waited[3:0]}, {1'b0, 4'h1});
        chk({O_ILLEGAL, O_MEM_WR, O_WORKING_REGISTER_WR, O_FLAGS_WR}, 4'h8);
        I_INSTR_VALID = 1'b0;
        @(posedge I_MCLK);
        #1;
    endtask
    initial begin
        {I_RESETN, I_INSTR_VALID, I_CARRY, I_INSTR} = '0;
        {I_BANK_SELECT_REGISTER, I_WORKING_REGISTER, I_MEM_RDATA} = '0;
        repeat (2) @(posedge I_MCLK);
        #1;
        I_RESETN = 1'b1;
        t_negate();
        t_sub();
        t_illegal();
        tally_and_finish();
    end
endmodule
